// [src/adc_mon_compare.sv]
// relation check between one conversion result and the comparison value
// assumes both values are 12-bit unsigned and come from the same clock domain
`timescale 1ns/1ps
module adc_mon_compare
  import adc_mon_pkg::*;
(
  input wire logic [11:0] result,
  input wire logic [11:0] reference,
  input wire adc_mon_pkg::dir_t direction,
  output logic hit
);
  // strict relations: equal values never match in either direction
  always_comb begin
    if (direction == DIR_LARGER) begin
      hit = result > reference;
    end else begin
      hit = result < reference;
    end
  end
endmodule : adc_mon_compare

// [src/adc_mon_counter.sv]
// match counter with continuous and cumulative counting policies
// assumes compare events are single-cycle strobes on clk
`timescale 1ns/1ps
module adc_mon_counter
  import adc_mon_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic event_valid,
  input wire logic hit,
  input wire adc_mon_pkg::method_t method,
  input wire logic [3:0] threshold,
  output logic [4:0] count_q,
  output logic fire
);
  logic [4:0] count_d;
  logic [4:0] target;

  // required matches are field plus one
  assign target = {1'b0, threshold} + 5'h01;

  // next count and fire decision
  always_comb begin
    count_d = count_q;
    fire = 1'b0;
    if (!enable) begin
      count_d = 5'h00;
    end else if (event_valid) begin
      if (hit) begin
        if (method == METHOD_CONTINUOUS) begin
          // saturate at target so each further match fires again
          if (count_q >= target) begin
            fire = 1'b1;
          end else begin
            count_d = count_q + 5'h01;
            fire = (count_q + 5'h01) == target;
          end
        end else begin
          if ((count_q + 5'h01) >= target) begin
            fire = 1'b1;
            count_d = 5'h00;
          end else begin
            count_d = count_q + 5'h01;
          end
        end
      end else if (method == METHOD_CONTINUOUS) begin
        count_d = 5'h00;
      end // cumulative mismatch holds the count
    end
  end

  // counter register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : adc_mon_counter

// [src/adc_mon_pkg.sv]
// package for the converter result monitor: register map, field layout, reset values
// assumes a 32-bit byte-addressed register bus with one aligned word per register
package adc_mon_pkg;
  // register byte offsets
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] COMPARE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] COUNT_OFS = 8'h14;
  // control field positions
  localparam int CHAN_LSB = 0;
  localparam int DIR_BIT = 4;
  localparam int METHOD_BIT = 5;
  localparam int ENABLE_BIT = 7;
  localparam int THRESH_LSB = 8;
  // status bit positions
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_BADCHAN_BIT = 1;
  localparam int STAT_WIDTH = 2;
  // reset values
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [11:0] COMPARE_RST = 12'h000;
  localparam logic [3:0] BAD_CHAN = 4'hF;
  // bus transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // counting policy and relation encodings
  typedef enum logic {METHOD_CONTINUOUS = 1'b0, METHOD_CUMULATIVE = 1'b1} method_t;
  typedef enum logic {DIR_LARGER = 1'b0, DIR_SMALLER = 1'b1} dir_t;
endpackage : adc_mon_pkg

// [src/adc_result_window_monitor.sv]
// monitor unit 1: watches one channel's conversion results, counts relation matches
// assumes the sequencer gives one-cycle result strobes on clk and an AHB-Lite master
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module adc_result_window_monitor
  import adc_mon_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // conversion results from the sequencer
  input wire logic resultValid,
  input wire logic [3:0] resultChannel,
  input wire logic [11:0] resultData,
  // event outputs
  output logic monitorIrq,
  output logic irqLine
);
  // control fields
  logic [3:0] channel_q;
  logic direction_q;
  logic method_q;
  logic enable_q;
  logic [3:0] threshold_q;
  logic [11:0] compareValue_q;
  logic [STAT_WIDTH-1:0] status_q;
  logic [STAT_WIDTH-1:0] irqEnable_q;
  // bus address phase capture
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_d;
  // monitor datapath
  logic eventValid;
  logic hit;
  logic fire;
  logic [4:0] count;
  logic pulse_q;
  logic badChan;
  logic [STAT_WIDTH-1:0] statusSet;
  logic [STAT_WIDTH-1:0] statusClr;
  logic takeXfer;

  // word offset decode shared by write and read paths
  function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
    isReg = (a[7:2] == ofs[7:2]);
  endfunction : isReg

  // single-cycle slave: no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign takeXfer = hsel && hready && (htrans == HTRANS_NONSEQ);

  // capture address phase for the following data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wrPend_q <= takeXfer && hwrite;
      rdPend_q <= takeXfer && !hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // control register: write during data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_q <= CONTROL_RST[CHAN_LSB +: 4];
      direction_q <= CONTROL_RST[DIR_BIT];
      method_q <= CONTROL_RST[METHOD_BIT];
      enable_q <= CONTROL_RST[ENABLE_BIT];
      threshold_q <= CONTROL_RST[THRESH_LSB +: 4];
    end else if (wrPend_q && isReg(addr_q, CONTROL_OFS)) begin
      channel_q <= hwdata[CHAN_LSB +: 4];
      direction_q <= hwdata[DIR_BIT];
      method_q <= hwdata[METHOD_BIT];
      enable_q <= hwdata[ENABLE_BIT];
      threshold_q <= hwdata[THRESH_LSB +: 4];
    end
  end

  // reference value register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compareValue_q <= COMPARE_RST;
    end else if (wrPend_q && isReg(addr_q, COMPARE_OFS)) begin
      compareValue_q <= hwdata[11:0];
    end
  end

  // interrupt enable register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqEnable_q <= '0;
    end else if (wrPend_q && isReg(addr_q, IRQ_EN_OFS)) begin
      irqEnable_q <= hwdata[STAT_WIDTH-1:0];
    end
  end

  // only results of the selected channel are compared
  assign eventValid = resultValid && (resultChannel == channel_q) && enable_q;

  adc_mon_compare u_compare (
    .result(resultData),
    .reference(compareValue_q),
    .direction(dir_t'(direction_q)),
    .hit(hit)
  );

  adc_mon_counter u_counter (
    .clk(clk),
    .nrst(nrst),
    .enable(enable_q),
    .event_valid(eventValid),
    .hit(hit),
    .method(method_t'(method_q)),
    .threshold(threshold_q),
    .count_q(count),
    .fire(fire)
  );

  // registered event pulse, one cycle after the comparison
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= fire;
    end
  end
  assign monitorIrq = pulse_q;

  // flag a forbidden channel code while enabled; the hardware still compares and counts results on that channel
  assign badChan = enable_q && (channel_q == BAD_CHAN);

  // sticky status: set wins over a clear in the same cycle
  always_comb begin
    statusSet = '0;
    statusSet[STAT_MATCH_BIT] = pulse_q;
    statusSet[STAT_BADCHAN_BIT] = badChan;
    statusClr = '0;
    if (wrPend_q && isReg(addr_q, IRQ_CLR_OFS)) begin
      statusClr = hwdata[STAT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~statusClr) | statusSet;
    end
  end

  // level interrupt while any enabled status bit stands
  assign irqLine = |(status_q & irqEnable_q);

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (isReg(addr_q, CONTROL_OFS)) begin
      rdata_d[CHAN_LSB +: 4] = channel_q;
      rdata_d[DIR_BIT] = direction_q;
      rdata_d[METHOD_BIT] = method_q;
      rdata_d[ENABLE_BIT] = enable_q;
      rdata_d[THRESH_LSB +: 4] = threshold_q;
    end else if (isReg(addr_q, COMPARE_OFS)) begin
      rdata_d[11:0] = compareValue_q;
    end else if (isReg(addr_q, STATUS_OFS)) begin
      rdata_d[STAT_WIDTH-1:0] = status_q;
    end else if (isReg(addr_q, IRQ_EN_OFS)) begin
      rdata_d[STAT_WIDTH-1:0] = irqEnable_q;
    end else if (isReg(addr_q, COUNT_OFS)) begin
      rdata_d[4:0] = count;
    end
  end

  // read data is driven combinationally from registers during the data phase
  assign hrdata = rdPend_q ? rdata_d : 32'h0000_0000;
endmodule : adc_result_window_monitor

// [tb/adc_mon_props.sv]
// checker for the result monitor, watching only its top-level ports
// assumes single word transfers; bound onto adc_result_window_monitor below
`timescale 1ns/1ps
module adc_mon_props
  import adc_mon_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic resultValid,
  input wire logic [3:0] resultChannel,
  input wire logic [11:0] resultData,
  input wire logic monitorIrq,
  input wire logic irqLine
);
  import adc_mon_pkg::*;
  logic wrPh_q, rdPh_q;
  logic [7:0] adr_q;
  logic [31:0] ctrl_q;
  logic [11:0] cmp_q;
  logic [1:0] ien_q;
  wire take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire acc = resultValid && ctrl_q[ENABLE_BIT] && resultChannel == ctrl_q[3:0];
  wire rel = ctrl_q[DIR_BIT] ? resultData < cmp_q : resultData > cmp_q;
  // shadow of the writable registers, so reactions can be tied to settings
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {wrPh_q, rdPh_q, adr_q} <= '0;
      ctrl_q <= CONTROL_RST;
      cmp_q <= COMPARE_RST;
      ien_q <= 2'h0;
    end else begin
      {wrPh_q, rdPh_q, adr_q} <= {take && hwrite, take && !hwrite, haddr[7:0]};
      if (wrPh_q && adr_q == CONTROL_OFS) ctrl_q <= hwdata;
      if (wrPh_q && adr_q == COMPARE_OFS) cmp_q <= hwdata[11:0];
      if (wrPh_q && adr_q == IRQ_EN_OFS) ien_q <= hwdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence firstHit;
    acc && rel && ctrl_q[11:8] == 4'h0;
  endsequence
  // enable dropped in the same edge would legally hide the level
  sequence evtKept;
    monitorIrq && ien_q[STAT_MATCH_BIT] ##1 ien_q[STAT_MATCH_BIT];
  endsequence
  AST_READY: assert property (hreadyout)
    else $error("wait state inserted");
  AST_OKAY: assert property (!hresp)
    else $error("error response given");
  AST_RDIDLE: assert property (!rdPh_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_CAUSE: assert property (monitorIrq |-> $past(acc))
    else $error("pulse without accepted result");
  AST_RELATION: assert property (monitorIrq |-> $past(rel))
    else $error("pulse after a failed relation");
  AST_ONE: assert property (firstHit |=> monitorIrq)
    else $error("single match did not fire");
  AST_MISS: assert property (acc && !rel |=> !monitorIrq)
    else $error("mismatch fired");
  AST_IDLE: assert property (!acc |=> !monitorIrq)
    else $error("pulse while idle or disabled");
  AST_RAISE: assert property (evtKept |-> irqLine)
    else $error("enabled event gave no level");
  AST_MASK: assert property (irqLine |-> ien_q != 2'h0)
    else $error("level with all sources masked");
endmodule : adc_mon_props

bind adc_result_window_monitor adc_mon_props u_props (.clk, .nrst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .resultValid, .resultChannel,
  .resultData, .monitorIrq, .irqLine);

// [tb/adc_seq_model.sv]
// result source standing in for the converter sequencer
// assumes the caller enters send just after a rising clk edge
`timescale 1ns/1ps
module adc_seq_model (
  input wire logic clk,
  output logic resultValid,
  output logic [3:0] resultChannel,
  output logic [11:0] resultData
);
  initial begin
    resultValid = 1'h0;
    resultChannel = 4'h0;
    resultData = 12'h0;
  end
  // one strobe per conversion as in repeat mode; gap 0 keeps the strobe up
  task automatic send(input logic [3:0] c, input logic [11:0] d, input int gap);
    resultValid <= 1'h1;
    resultChannel <= c;
    resultData <= d;
    @(posedge clk);
    if (gap > 0) resultValid <= 1'h0;
    // stale lines flip each cycle so nothing leans on old values
    repeat (gap) begin
      resultData <= ~resultData;
      resultChannel <= ~resultChannel;
      @(posedge clk);
    end
  endtask : send
endmodule : adc_seq_model

// [tb/tb_adc_result_window_monitor.sv]
// bench for the result monitor: bus master, reference counter, expectation queues
// assumes the sequencer model and the bound checker in the same folder
`timescale 1ns/1ps
module tb_adc_result_window_monitor;
  import adc_mon_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, hwrite = 1'h0, rdPh = 1'h0, vPh = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ctrl;
  logic hreadyout, hresp, monitorIrq, irqLine, resultValid;
  logic [3:0] resultChannel;
  logic [11:0] resultData, cmp;
  logic [4:0] cnt;
  logic [31:0] rdQ[$];
  logic irqQ[$];
  int miscompares = 0, n_compared = 0, seed = 32'h5da1, sel;
  initial forever #2 clk = ~clk;
  adc_result_window_monitor u_dut (.clk, .nrst, .hsel(1'h1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .resultValid,
    .resultChannel, .resultData, .monitorIrq, .irqLine);
  adc_seq_model u_seq (.clk, .resultValid, .resultChannel, .resultData);
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // single transfer; a read notes its expected data for the watcher
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    if (!w) rdQ.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
  endtask : bus
  task automatic setc(input logic [31:0] v);
    ctrl = v;
    if (!v[ENABLE_BIT]) cnt = 5'h0;
    bus(CONTROL_OFS, 1'h1, v);
  endtask : setc
  // reference counter predicts the pulse for every result sent
  task automatic res(input logic [3:0] c, input logic [11:0] d, input int gap);
    logic hit, fire;
    logic [4:0] t;
    t = {1'h0, ctrl[THRESH_LSB +: 4]};
    hit = ctrl[DIR_BIT] ? d < cmp : d > cmp;
    fire = 1'h0;
    if (ctrl[ENABLE_BIT] && c == ctrl[3:0]) begin
      if (!ctrl[METHOD_BIT]) begin
        cnt = hit ? (cnt > t ? cnt : cnt + 5'h1) : 5'h0;
        fire = hit && cnt > t;
      end else if (hit) begin
        cnt = cnt + 5'h1;
        fire = cnt > t;
        if (fire) cnt = 5'h0;
      end
    end
    irqQ.push_back(fire);
    u_seq.send(c, d, gap);
  endtask : res
  // judged mid-cycle, where registered outputs have settled
  always @(posedge clk) begin
    rdPh <= htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
    vPh <= resultValid;
  end
  always @(negedge clk) begin
    if (rdPh) chk(hrdata, rdQ.pop_front(), "hrdata");
    if (vPh) chk(monitorIrq, irqQ.pop_front(), "irq");
    else chk(monitorIrq, 32'h0, "irq idle");
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    ctrl = 32'h0;
    cnt = 5'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    bus(CONTROL_OFS, 1'h0, CONTROL_RST);
    bus(COMPARE_OFS, 1'h0, 32'h0);
    bus(8'h40, 1'h1, 32'hFFFF_FFFF);
    bus(8'h40, 1'h0, 32'h0);
    $display("test reset done");
    // every relation with every counting policy; cumulative at the top threshold
    for (int i = 0; i < 4; i++) begin
      cmp = 12'({$random(seed)} % 4094 + 1);
      bus(COMPARE_OFS, 1'h1, {20'h0, cmp});
      bus(COMPARE_OFS, 1'h0, {20'h0, cmp});
      setc({20'h0, 4'(i[1] ? 15 : {$random(seed)} % 4), 2'h2, i[1], i[0],
        4'({$random(seed)} % 12)});
      bus(CONTROL_OFS, 1'h0, ctrl & 32'hFBF);
      for (int k = 0; k < 40; k++) begin
        sel = {$random(seed)} % 8;
        res(sel == 7 ? ctrl[3:0] + 4'h1 : ctrl[3:0], sel == 0 ? cmp :
          ((sel == 1) == ctrl[DIR_BIT]) ? cmp + 12'h1 : cmp - 12'h1, (sel % 3) | (k == 39));
      end
      bus(COUNT_OFS, 1'h0, {27'h0, cnt});
      setc(ctrl & ~32'h80);
      bus(COUNT_OFS, 1'h0, 32'h0);
      $display("test %0d done", i);
    end
    // raise, clear and mask the interrupt level; earlier tests left the sticky bit set
    setc(32'h82);
    bus(IRQ_CLR_OFS, 1'h1, 32'h3);
    bus(IRQ_EN_OFS, 1'h1, 32'h1);
    @(negedge clk);
    chk(irqLine, 32'h0, "irqLine quiet");
    @(posedge clk);
    res(4'h2, cmp + 12'h1, 2);
    chk(irqLine, 32'h1, "irqLine");
    bus(STATUS_OFS, 1'h0, 32'h1);
    bus(IRQ_CLR_OFS, 1'h1, 32'h1);
    @(negedge clk);
    chk(irqLine, 32'h0, "irqLine cleared");
    @(posedge clk);
    bus(IRQ_EN_OFS, 1'h1, 32'h0);
    res(4'h2, cmp + 12'h1, 2);
    chk(irqLine, 32'h0, "irqLine masked");
    bus(STATUS_OFS, 1'h0, 32'h1);
    bus(IRQ_CLR_OFS, 1'h1, 32'h1);
    bus(STATUS_OFS, 1'h0, 32'h0);
    $display("test irq done");
    results();
  end
endmodule : tb_adc_result_window_monitor
